// File: design/trace_pin_output_core.sv
// Trace pin output core: bank multiplexer, capture pipeline and pin drive.
// Assumes banks arrive on TRACE_CAP_CLK_I; software reaches CTRL/STATUS over
// AXI4-Lite on CLK_I. The two clocks are unrelated.
`timescale 1ns/1ns
module trace_pin_output_core
    import trace_pkg::*;
#(
    parameter int PIN_COUNT  = PIN_COUNT_DEFAULT,
    parameter int BANK_COUNT = BANK_COUNT_DEFAULT,
    parameter int TDM_RATE   = TDM_RATE_DEFAULT,
    parameter bit ASYNC_MODE = ASYNC_DEFAULT,
    parameter bit ALWAYS_ON  = ALWAYS_ON_DEFAULT,
    // derived; do not override
    parameter int PINS       = (PIN_COUNT < PIN_COUNT_MIN) ? PIN_COUNT_MIN :
                               (PIN_COUNT > PIN_COUNT_MAX) ? PIN_COUNT_MAX : PIN_COUNT,
    parameter int RATE       = (ASYNC_MODE || TDM_RATE < 2) ? 1 : 2,
    parameter int BANK_W     = ASYNC_MODE ? (PINS + 1) * RATE : PINS * RATE
) (
    input  wire logic                         CLK_I,
    input  wire logic                         RST_I,
    input  wire logic                         CE_I,
    input  wire logic                         TRACE_CAP_CLK_I,
    input  wire logic [BANK_COUNT*BANK_W-1:0] BANK_DATA_I,
    // AXI4-Lite slave
    input  wire logic [3:0]                   S_AXI_AWADDR_I,
    input  wire logic                         S_AXI_AWVALID_I,
    output logic                              S_AXI_AWREADY_O,
    input  wire logic [31:0]                  S_AXI_WDATA_I,
    input  wire logic [3:0]                   S_AXI_WSTRB_I,
    input  wire logic                         S_AXI_WVALID_I,
    output logic                              S_AXI_WREADY_O,
    output logic [1:0]                        S_AXI_BRESP_O,
    output logic                              S_AXI_BVALID_O,
    input  wire logic                         S_AXI_BREADY_I,
    input  wire logic [3:0]                   S_AXI_ARADDR_I,
    input  wire logic                         S_AXI_ARVALID_I,
    output logic                              S_AXI_ARREADY_O,
    output logic [31:0]                       S_AXI_RDATA_O,
    output logic [1:0]                        S_AXI_RRESP_O,
    output logic                              S_AXI_RVALID_O,
    input  wire logic                         S_AXI_RREADY_I,
    // trace pins
    output logic [PINS-1:0]                   TRACE_DATA_O,
    output logic [PINS-1:0]                   TRACE_DATA_OE_O,
    output logic                              TRACE_CLK_O,
    output logic                              TRACE_CLK_OE_O
);

    // ------------------------------------------------------------------
    // derived build settings
    // ------------------------------------------------------------------
    // always-on only exists when built asynchronous
    localparam bit ON_AT_RESET = ALWAYS_ON && ASYNC_MODE;
    // bank count snapped down to a legal power of two
    localparam int BANKS = (BANK_COUNT >= 64) ? 64 : (BANK_COUNT >= 32) ? 32 :
                           (BANK_COUNT >= 16) ? 16 : (BANK_COUNT >= 8) ? 8 :
                           (BANK_COUNT >= 4) ? 4 : (BANK_COUNT >= 2) ? 2 : 1;
    localparam logic [CTRL_BANK_WIDTH-1:0] BANK_MASK = CTRL_BANK_WIDTH'(BANKS - 1);

    // ------------------------------------------------------------------
    // register bus (CLK_I domain)
    // ------------------------------------------------------------------
    logic                        enable;
    logic [CTRL_BANK_WIDTH-1:0]  bank_sel;
    logic                        sel_toggle;
    logic                        aw_held;
    logic [3:0]                  aw_addr;
    logic                        w_held;
    logic [31:0]                 w_data;
    logic [3:0]                  w_strb;
    logic                        active_sys;
    logic                        do_write;
    logic [31:0]                 ctrl_word;
    logic [31:0]                 next_ctrl;
    logic [31:0]                 status_word;

    // readies drop while frozen so that no beat is handshaken and then lost
    assign S_AXI_AWREADY_O = CE_I && !aw_held && !S_AXI_BVALID_O;
    assign S_AXI_WREADY_O  = CE_I && !w_held && !S_AXI_BVALID_O;
    assign S_AXI_ARREADY_O = CE_I && !S_AXI_RVALID_O;
    assign do_write        = CE_I && aw_held && w_held && !S_AXI_BVALID_O;

    assign ctrl_word = {16'h0000, 2'h0, bank_sel, 7'h00, enable};

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            next_ctrl[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : ctrl_word[b*8 +: 8];
        end
    end

    assign status_word = {1'b0, 7'(BANKS), 6'h00, 2'(RATE), 1'b0, 7'(PINS),
                          6'h00, ASYNC_MODE, active_sys};

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
        end else if (CE_I) begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR_I;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (CE_I) begin
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA_I;
                w_strb <= S_AXI_WSTRB_I;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // enable and bank select; always-on comes up driving bank 0
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            enable     <= ON_AT_RESET;
            bank_sel   <= BANK_RESET;
            sel_toggle <= 1'b0;
        end else if (CE_I && do_write && aw_addr == CTRL_OFFSET) begin
            enable     <= next_ctrl[CTRL_ENABLE_BIT];
            bank_sel   <= next_ctrl[CTRL_BANK_LSB +: CTRL_BANK_WIDTH] & BANK_MASK;
            sel_toggle <= !sel_toggle;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O  <= RESP_OKAY;
        end else if (CE_I) begin
            if (do_write) begin
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O  <= (aw_addr == CTRL_OFFSET) ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O  <= 32'h0000_0000;
            S_AXI_RRESP_O  <= RESP_OKAY;
        end else if (CE_I) begin
            if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
                S_AXI_RVALID_O <= 1'b1;
                case (S_AXI_ARADDR_I)
                    CTRL_OFFSET: begin
                        S_AXI_RDATA_O <= ctrl_word;
                        S_AXI_RRESP_O <= RESP_OKAY;
                    end
                    STATUS_OFFSET: begin
                        S_AXI_RDATA_O <= status_word;
                        S_AXI_RRESP_O <= RESP_OKAY;
                    end
                    default: begin
                        S_AXI_RDATA_O <= 32'h0000_0000;
                        S_AXI_RRESP_O <= RESP_SLVERR;
                    end
                endcase
            end else if (S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // clock domain crossing
    // ------------------------------------------------------------------
    logic [2:0]                 link_sync;
    logic                       enable_link;
    logic                       ce_link;
    logic                       toggle_link;
    logic                       toggle_seen;
    logic [CTRL_BANK_WIDTH-1:0] sel_link;
    logic                       active_link;

    level_sync #(
        .WIDTH     (3),
        .RESET_VAL ({61'h0, ON_AT_RESET, 1'b1, 1'b0})
    ) u_to_link (
        .clk_i (TRACE_CAP_CLK_I),
        .rst_i (RST_I),
        .d_i   ({enable, CE_I, sel_toggle}),
        .q_o   (link_sync)
    );

    assign enable_link = link_sync[2];
    assign ce_link     = link_sync[1];
    assign toggle_link = link_sync[0];

    level_sync #(
        .WIDTH     (1),
        .RESET_VAL ({63'h0, ON_AT_RESET})
    ) u_to_sys (
        .clk_i (CLK_I),
        .rst_i (RST_I),
        .d_i   (active_link),
        .q_o   (active_sys)
    );

    // bank_sel is held stable from its write until the toggle arrives, so
    // sampling it on the toggle edge is safe; writes closer than ~3 link
    // cycles apart may be merged into the later one
    always_ff @(posedge TRACE_CAP_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            toggle_seen <= 1'b0;
            sel_link    <= BANK_RESET;
        end else if (ce_link && toggle_link != toggle_seen) begin
            toggle_seen <= toggle_link;
            sel_link    <= bank_sel;
        end
    end

    always_ff @(posedge TRACE_CAP_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            active_link <= ON_AT_RESET;
        end else if (ce_link) begin
            active_link <= enable_link;
        end
    end

    // ------------------------------------------------------------------
    // bank multiplexer and pin drive
    // ------------------------------------------------------------------
    logic [BANK_W-1:0] bank_word;

    // run-time bank select, streamed with no storage
    assign bank_word = BANK_DATA_I[32'(sel_link) * BANK_W +: BANK_W];

    assign TRACE_DATA_OE_O = {PINS{active_link}};
    assign TRACE_CLK_OE_O  = active_link;

    generate
        if (ASYNC_MODE) begin : g_async
            // no flops from bank to pins; top bit rides the clock pin
            assign TRACE_DATA_O = active_link ? bank_word[PINS-1:0] : '0;
            assign TRACE_CLK_O  = active_link && bank_word[PINS];
        end else begin : g_sync
            logic [BANK_W-1:0] pipe_a;
            logic [BANK_W-1:0] pipe_b;

            // two pipeline stages on the capture clock
            always_ff @(posedge TRACE_CAP_CLK_I or posedge RST_I) begin
                if (RST_I) begin
                    pipe_a <= '0;
                    pipe_b <= '0;
                end else if (ce_link) begin
                    pipe_a <= active_link ? bank_word : '0;
                    pipe_b <= pipe_a;
                end
            end

            // forwarded capture clock marks each word
            assign TRACE_CLK_O = active_link && TRACE_CAP_CLK_I;

            if (RATE == 2) begin : g_ddr
                // high phase follows the rising edge: low half, then upper half
                assign TRACE_DATA_O = TRACE_CAP_CLK_I ? pipe_b[PINS-1:0]
                                                      : pipe_b[BANK_W-1:PINS];
            end else begin : g_sdr
                assign TRACE_DATA_O = pipe_b;
            end
        end
    endgenerate

endmodule

// File: design/trace_pkg.sv
// Constants, register map and build defaults for the trace pin output block.
// Assumes one software clock domain (CLK_I) and one capture clock domain (the link clock).
//
// What this block does
// - synchronous mode pipelines trace data through flops on the capture clock
// - asynchronous mode path from bank to pins is purely combinational
// - trace clock pin is a clock when synchronous, an extra data bit otherwise
// - bank width is pins times rate, or pins plus one times rate
// - output runs at input rate (1x) or twice it (2x)
// - 2x rate only allowed in synchronous mode; asynchronous is forced to 1x
// - trace data pin count is a build parameter from 4 to 64
// - run-time selectable bank multiplexer with 1,2,4,8,16,32 or 64 banks
// - always-enabled option drives bank 0 out from reset without setup
// - always-enabled option defaults off and only exists in asynchronous mode
// - no on-chip storage; selected data streams out continuously
package trace_pkg;

    // ------------------------------------------------------------------
    // build defaults
    // ------------------------------------------------------------------
    localparam int PIN_COUNT_DEFAULT  = 8;
    localparam int PIN_COUNT_MIN      = 4;
    localparam int PIN_COUNT_MAX      = 64;
    localparam int BANK_COUNT_DEFAULT = 4;
    localparam int BANK_COUNT_MAX     = 64;
    localparam int TDM_RATE_DEFAULT   = 2;
    localparam bit ASYNC_DEFAULT      = 1'b0;
    localparam bit ALWAYS_ON_DEFAULT  = 1'b0;
    localparam int SYNC_STAGES        = 2;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0] CTRL_OFFSET   = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;

    localparam int CTRL_ENABLE_BIT   = 0;
    localparam int CTRL_BANK_LSB     = 8;
    localparam int CTRL_BANK_WIDTH   = 6;

    localparam int STAT_ACTIVE_BIT   = 0;
    localparam int STAT_ASYNC_BIT    = 1;
    localparam int STAT_PINS_LSB     = 8;
    localparam int STAT_RATE_LSB     = 16;
    localparam int STAT_BANKS_LSB    = 24;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [CTRL_BANK_WIDTH-1:0] BANK_RESET = 6'h00;

endpackage

// File: design/level_sync.sv
// Two flip-flop synchroniser for a group of independent level signals.
// Assumes each bit is quasi-static relative to the destination clock.
`timescale 1ns/1ns
module level_sync
    import trace_pkg::*;
#(
    parameter int          WIDTH     = 1,
    parameter logic [63:0] RESET_VAL = 64'h0
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= RESET_VAL[WIDTH-1:0];
            q_o  <= RESET_VAL[WIDTH-1:0];
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule

// File: verif/trace_pin_output_core_properties.sv
// Port-level assertions for the trace pin output core.
// Assumes the synchronous build; link-side pins are sampled on CLK_I.
`timescale 1ns/1ns
module trace_pin_output_core_checker
    import trace_pkg::*;
#(
    parameter int PINS = 8
) (
    input wire logic            CLK_I,
    input wire logic            RST_I,
    input wire logic            TRACE_CAP_CLK_I,
    input wire logic [3:0]      S_AXI_AWADDR_I,
    input wire logic            S_AXI_AWVALID_I,
    input wire logic            S_AXI_AWREADY_O,
    input wire logic            S_AXI_WVALID_I,
    input wire logic            S_AXI_WREADY_O,
    input wire logic [1:0]      S_AXI_BRESP_O,
    input wire logic            S_AXI_BVALID_O,
    input wire logic            S_AXI_BREADY_I,
    input wire logic            S_AXI_ARVALID_I,
    input wire logic            S_AXI_ARREADY_O,
    input wire logic [31:0]     S_AXI_RDATA_O,
    input wire logic            S_AXI_RVALID_O,
    input wire logic            S_AXI_RREADY_I,
    input wire logic [PINS-1:0] TRACE_DATA_O,
    input wire logic [PINS-1:0] TRACE_DATA_OE_O,
    input wire logic            TRACE_CLK_O,
    input wire logic            TRACE_CLK_OE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    sequence wr_taken;
        S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
    endsequence

    // both beats sit in their holding flops for one cycle before the response launches
    a_write_answer: assert property (wr_taken |-> ##2 S_AXI_BVALID_O)
        else $error("write response late");
    a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("read response late");
    a_bresp_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
        |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write response dropped");
    a_rdata_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
        |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read data dropped");
    a_read_single: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
        else $error("read accepted while answer pending");
    a_unmapped_slverr: assert property (wr_taken ##0
        (S_AXI_AWADDR_I[3] || S_AXI_AWADDR_I == STATUS_OFFSET)
        |-> ##2 S_AXI_BRESP_O == RESP_SLVERR) else $error("bad write not refused");
    a_oe_together: assert property (TRACE_DATA_OE_O == {PINS{TRACE_CLK_OE_O}})
        else $error("pin enables disagree");
    a_clock_gated: assert property (TRACE_CLK_O == (TRACE_CAP_CLK_I && TRACE_CLK_OE_O))
        else $error("trace clock pin wrong");
    // pins move only with the capture clock: pipelined and split by its level
    a_data_on_link: assert property ($changed(TRACE_DATA_O) |-> $changed(TRACE_CAP_CLK_I))
        else $error("trace data changed off the capture clock");

    c_write: cover property (wr_taken);
    c_read: cover property (S_AXI_ARVALID_I && S_AXI_ARREADY_O);
    c_enable: cover property ($rose(TRACE_CLK_OE_O));
endmodule

bind trace_pin_output_core trace_pin_output_core_checker #(.PINS(PINS)) checker_i (
    .CLK_I(CLK_I), .RST_I(RST_I), .TRACE_CAP_CLK_I(TRACE_CAP_CLK_I),
    .S_AXI_AWADDR_I(S_AXI_AWADDR_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
    .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
    .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
    .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
    .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
    .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
    .S_AXI_RREADY_I(S_AXI_RREADY_I), .TRACE_DATA_O(TRACE_DATA_O),
    .TRACE_DATA_OE_O(TRACE_DATA_OE_O), .TRACE_CLK_O(TRACE_CLK_O),
    .TRACE_CLK_OE_O(TRACE_CLK_OE_O));

// File: verif/trace_analyzer_model.sv
// External analyzer on the trace pins: rebuilds one 2x word per trace clock.
// Assumes the synchronous 2x build and a 64 ns trace clock.
`timescale 1ns/1ns
module trace_analyzer_model #(
    parameter int PINS = 8
) (
    input wire logic            trace_clk_i,
    input wire logic [PINS-1:0] trace_data_i,
    output logic [2*PINS-1:0]   word_o
);
    logic [PINS-1:0] low_half;

    initial word_o = '0;
    // sample mid-phase, well clear of both pin transitions
    always @(posedge trace_clk_i) begin
        #16;
        low_half = trace_data_i;
    end
    always @(negedge trace_clk_i) begin
        #16;
        word_o = {trace_data_i, low_half};
    end
endmodule

// File: verif/test_trace_pin_output_core.sv
// Bench for the trace pin output core: register accesses and pin capture.
// Assumes the default synchronous 2x build with 8 pins and 4 banks.
`timescale 1ns/1ns
module test_trace_pin_output_core
    import trace_pkg::*;
;
    localparam int PC = 8;
    localparam int BC = 4;
    localparam int BW = 16;
    localparam logic [31:0] STAT = (32'(BC) << STAT_BANKS_LSB) | (32'(2) << STAT_RATE_LSB)
                                 | (32'(PC) << STAT_PINS_LSB);
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic            link_clk = 1'b0;
    logic [BC*BW-1:0] banks;
    logic [3:0]      awaddr, araddr, wstrb;
    logic            awvalid, wvalid, bready, arvalid, rready;
    logic            awready, wready, bvalid, arready, rvalid;
    logic [31:0]     wdata, rdata;
    logic [1:0]      bresp, rresp;
    logic [PC-1:0]   tdata, toe;
    logic            tclk, tclk_oe;
    logic [2*PC-1:0] word;
    int              num_errors = 0;
    int              tests_run = 0;
    int              k;

    always #2 clk = ~clk;
    initial begin
        #1;
        forever #32 link_clk = ~link_clk;
    end

    trace_pin_output_core trace_pin_output_core_i (
        .CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .TRACE_CAP_CLK_I(link_clk), .BANK_DATA_I(banks),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
        .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .TRACE_DATA_O(tdata),
        .TRACE_DATA_OE_O(toe), .TRACE_CLK_O(tclk), .TRACE_CLK_OE_O(tclk_oe));

    trace_analyzer_model #(.PINS(PC)) trace_analyzer_model_i (
        .trace_clk_i(tclk), .trace_data_i(tdata), .word_o(word));

    // ------------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------------
    task automatic test_done();
        if (num_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check_data(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: data %h expected %h", $time, g, e);
        end
    endtask

    task automatic check_resp(input logic [1:0] g, input logic [1:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: resp %h expected %h", $time, g, e);
        end
    endtask

    function automatic logic [15:0] bank_val(input int n);
        return 16'hC030 + 16'(n) * 16'h0101;
    endfunction

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        bit done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100 && !done; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                done = 1'b1;
                bready <= 1'b0;
                check_resp(bresp, er);
            end
        end
        if (!done) begin
            num_errors++;
            test_done();
        end
    endtask

    task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100 && !done; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                done = 1'b1;
                rready <= 1'b0;
                check_data(rdata, ed);
                check_resp(rresp, er);
            end
        end
        if (!done) begin
            num_errors++;
            test_done();
        end
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {awaddr, araddr, wstrb, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        for (k = 0; k < BC; k++) banks[k*BW +: BW] = bank_val(k);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        check_data(32'(toe), 32'h0);
        axi_read(CTRL_OFFSET, 32'h0, RESP_OKAY);
        axi_read(STATUS_OFFSET, STAT, RESP_OKAY);
        axi_read(4'h8, 32'h0, RESP_SLVERR);
        axi_write(4'hC, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
        axi_write(STATUS_OFFSET, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
        axi_read(STATUS_OFFSET, STAT, RESP_OKAY);
        axi_read(CTRL_OFFSET, 32'h0, RESP_OKAY);
        // banks 4 and 5 wrap onto 0 and 1 through the index mask
        for (k = 0; k < 6; k++) begin
            axi_write(CTRL_OFFSET, {18'h0, 6'(k), 7'h0, 1'b1}, 4'hF, RESP_OKAY);
            repeat (10) @(posedge link_clk);
            check_data(32'(word), 32'(bank_val(k % BC)));
            check_data(32'(toe), 32'h0000_00FF);
        end
        axi_read(STATUS_OFFSET, STAT | 32'h1, RESP_OKAY);
        axi_write(CTRL_OFFSET, 32'h0000_0200, 4'h2, RESP_OKAY);
        repeat (10) @(posedge link_clk);
        check_data(32'(word), 32'(bank_val(2)));
        axi_read(CTRL_OFFSET, 32'h0000_0201, RESP_OKAY);
        axi_write(CTRL_OFFSET, 32'h0, 4'hF, RESP_OKAY);
        repeat (10) @(posedge link_clk);
        check_data(32'(tdata), 32'h0);
        check_data(32'({toe, tclk_oe}), 32'h0);
        axi_read(STATUS_OFFSET, STAT, RESP_OKAY);
        test_done();
    end
endmodule
